//--- logic/poc_payload_count.sv
// Per-frame and cumulative good payload byte counters, receive and transmit.
// Assumes the MAC frame logic runs on sys_clk and gives one end-of-frame
// pulse per frame with its payload length and error flags in that cycle.
//
// Overview of operation
// R1: Keep 64-bit good payload totals per direction
// R2: Count only frames free of all four errors
// R3: Output 16-bit per-frame payload count with strobe
// R4: Strobe only for qualifying frames; else ignore count
// R5: Per-frame outputs work without statistics module
// R6: Each direction's outputs synchronous to its clock
// R7: Other increment outputs pulse exactly one cycle
// R8: Add per-frame count on strobe, wrapping total
`timescale 1ns/10ps
`include "poc_consts.svh"

module poc_payload_count (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Statistics module present and counting
    input  wire logic              stats_module_en,
    // Receive frame end report
    input  wire logic              rx_frame_end,
    input  wire poc_pkg::poc_count_t rx_frame_len,
    input  wire logic              rx_fcs_err,
    input  wire logic              rx_oversize_err,
    input  wire logic              rx_undersize_err,
    input  wire logic              rx_length_err,
    // Transmit frame end report
    input  wire logic              tx_frame_end,
    input  wire poc_pkg::poc_count_t tx_frame_len,
    input  wire logic              tx_fcs_err,
    input  wire logic              tx_oversize_err,
    input  wire logic              tx_undersize_err,
    input  wire logic              tx_length_err,
    // Receive results
    output logic                   rx_frame_payload_bytes_strobe,
    output poc_pkg::poc_count_t    rx_frame_payload_bytes,
    output logic                   rx_bad_frame_strobe,
    output poc_pkg::poc_total_t    rx_good_payload_byte_total,
    // Transmit results
    output logic                   tx_frame_payload_bytes_strobe,
    output poc_pkg::poc_count_t    tx_frame_payload_bytes,
    output logic                   tx_bad_frame_strobe,
    output poc_pkg::poc_total_t    tx_good_payload_byte_total
);
    import poc_pkg::*;

    // -----------------------------------------------------------------
    // Reset synchroniser
    // -----------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_n;

    // Release is synchronous so no register sees a partial reset edge.
    // Assertion takes effect at once; only the release is retimed, two
    // edges late, so a frame end must wait until the third edge.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    // -----------------------------------------------------------------
    // Direction arrays
    // -----------------------------------------------------------------
    logic       frame_end   [`POC_DIR_N];
    poc_count_t frame_len   [`POC_DIR_N];
    logic       frame_bad   [`POC_DIR_N];
    logic       strobe_q    [`POC_DIR_N];
    poc_count_t count_q     [`POC_DIR_N];
    logic       bad_q       [`POC_DIR_N];
    poc_total_t total_q     [`POC_DIR_N];

    // Gather the two directions so one loop serves both.
    // Both directions share sys_clk in this build, so no crossing is
    // needed; a split clock build would need one loop body per clock.
    assign frame_end[`POC_DIR_RX] = rx_frame_end;
    assign frame_end[`POC_DIR_TX] = tx_frame_end;
    assign frame_len[`POC_DIR_RX] = rx_frame_len;
    assign frame_len[`POC_DIR_TX] = tx_frame_len;
    assign frame_bad[`POC_DIR_RX] = rx_fcs_err | rx_oversize_err
                                  | rx_undersize_err | rx_length_err; // see R2
    assign frame_bad[`POC_DIR_TX] = tx_fcs_err | tx_oversize_err
                                  | tx_undersize_err | tx_length_err; // see R2

    // Results straight from flip-flops
    assign rx_frame_payload_bytes_strobe = strobe_q[`POC_DIR_RX];
    assign rx_frame_payload_bytes        = count_q[`POC_DIR_RX];
    assign rx_bad_frame_strobe           = bad_q[`POC_DIR_RX];
    assign rx_good_payload_byte_total    = total_q[`POC_DIR_RX];
    assign tx_frame_payload_bytes_strobe = strobe_q[`POC_DIR_TX];
    assign tx_frame_payload_bytes        = count_q[`POC_DIR_TX];
    assign tx_bad_frame_strobe           = bad_q[`POC_DIR_TX];
    assign tx_good_payload_byte_total    = total_q[`POC_DIR_TX];

    // -----------------------------------------------------------------
    // Per-direction counting
    // -----------------------------------------------------------------
    for (genvar d = 0; d < `POC_DIR_N; d++) begin : g_dir

        // Per-frame strobe, registered once per good frame end
        always_ff @(posedge sys_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                strobe_q[d] <= 1'b0;
            end else begin
                strobe_q[d] <= frame_end[d] & ~frame_bad[d]; // see R4 see R5 see R6
            end
        end

        // Count is loaded only for good frames; it holds otherwise,
        // so a bad frame never disturbs the last reported value
        always_ff @(posedge sys_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                count_q[d] <= `POC_COUNT_RST;
            end else if (frame_end[d] && !frame_bad[d]) begin
                count_q[d] <= frame_len[d]; // see R3
            end
        end

        // Errored frame event, single cycle per frame end
        always_ff @(posedge sys_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                bad_q[d] <= 1'b0;
            end else begin
                bad_q[d] <= frame_end[d] & frame_bad[d]; // see R7
            end
        end

        // Running total; the add wraps naturally at 64 bits.
        // Gated by the statistics enable, unlike the per-frame outputs.
        always_ff @(posedge sys_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                total_q[d] <= `POC_TOTAL_RST;
            end else if (strobe_q[d] && stats_module_en) begin
                total_q[d] <= total_q[d] + {{(`POC_TOTAL_W-`POC_COUNT_W){1'b0}},
                                            count_q[d]}; // see R1 see R8
            end
        end

        // -------------------------------------------------------------
        // Checks
        // -------------------------------------------------------------
        strobe_cause_a: assert property ( // see R4
            @(posedge sys_clk) disable iff (!rst_sync_n)
            strobe_q[d] |-> $past(frame_end[d]) && !$past(frame_bad[d]))
            else $error("Per-frame strobe without a good frame end");

        bad_blocks_a: assert property ( // see R2
            @(posedge sys_clk) disable iff (!rst_sync_n)
            frame_end[d] && frame_bad[d] |=> !strobe_q[d] && bad_q[d])
            else $error("Errored frame produced a per-frame strobe");

        count_value_a: assert property ( // see R3
            @(posedge sys_clk) disable iff (!rst_sync_n)
            frame_end[d] && !frame_bad[d] |=>
                strobe_q[d] && count_q[d] == $past(frame_len[d]))
            else $error("Per-frame count differs from frame length");

        bad_pulse_a: assert property ( // see R7
            @(posedge sys_clk) disable iff (!rst_sync_n)
            bad_q[d] && !(frame_end[d] && frame_bad[d]) |=> !bad_q[d])
            else $error("Errored frame event longer than one cycle");

        total_add_a: assert property ( // see R8
            @(posedge sys_clk) disable iff (!rst_sync_n)
            strobe_q[d] && stats_module_en |=>
                total_q[d] == $past(total_q[d])
                    + {{(`POC_TOTAL_W-`POC_COUNT_W){1'b0}}, $past(count_q[d])})
            else $error("Total did not add the per-frame count");

        total_hold_a: assert property ( // see R1
            @(posedge sys_clk) disable iff (!rst_sync_n)
            !(strobe_q[d] && stats_module_en) |=> $stable(total_q[d]))
            else $error("Total changed without a counted frame");

        stats_free_a: assert property ( // see R5
            @(posedge sys_clk) disable iff (!rst_sync_n)
            frame_end[d] && !frame_bad[d] && !stats_module_en ##1 1'b1
                |-> strobe_q[d])
            else $error("Per-frame strobe lost with statistics disabled");

        count_sync_a: assert property ( // see R6
            @(posedge sys_clk) disable iff (!rst_sync_n)
            !$past(frame_end[d]) |-> $stable(count_q[d]) && !strobe_q[d])
            else $error("Per-frame outputs moved without a frame end");

        // -------------------------------------------------------------
        // Exclusion, pulse and hold checks
        // -------------------------------------------------------------
        // A frame is either good or errored, never both at once
        strobe_excl_a: assert property ( // see R4
            @(posedge sys_clk) disable iff (!rst_sync_n)
            !(strobe_q[d] && bad_q[d]))
            else $error("Good and errored strobes together");

        bad_keeps_a: assert property ( // see R2
            @(posedge sys_clk) disable iff (!rst_sync_n)
            bad_q[d] |-> $stable(count_q[d]))
            else $error("Errored frame loaded the per-frame count");

        strobe_pulse_a: assert property ( // see R4
            @(posedge sys_clk) disable iff (!rst_sync_n)
            strobe_q[d] && !(frame_end[d] && !frame_bad[d]) |=> !strobe_q[d])
            else $error("Per-frame strobe longer than one cycle");

        count_hold_a: assert property ( // see R3
            @(posedge sys_clk) disable iff (!rst_sync_n)
            !(frame_end[d] && !frame_bad[d]) |=> $stable(count_q[d]))
            else $error("Per-frame count changed without a good frame");

        stats_gate_a: assert property ( // see R1
            @(posedge sys_clk) disable iff (!rst_sync_n)
            !stats_module_en |=> $stable(total_q[d]))
            else $error("Total moved with statistics disabled");
    end

endmodule

//--- logic/poc_consts.svh
// Widths and reset values for the payload byte counting block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef POC_CONSTS_SVH
`define POC_CONSTS_SVH

// -----------------------------------------------------------------
// Field widths and direction count
// -----------------------------------------------------------------
`define POC_COUNT_W      16
`define POC_TOTAL_W      64
`define POC_DIR_N        2

// -----------------------------------------------------------------
// Direction indices and reset values
// -----------------------------------------------------------------
`define POC_DIR_RX       0
`define POC_DIR_TX       1
`define POC_COUNT_RST    16'h0000
`define POC_TOTAL_RST    64'h0000_0000_0000_0000

`endif

//--- logic/poc_pkg.sv
// Types shared by the payload byte counting block.
// Assumes poc_consts.svh is on the include path.
`include "poc_consts.svh"

package poc_pkg;

    // -----------------------------------------------------------------
    // Data types
    // -----------------------------------------------------------------
    typedef logic [`POC_COUNT_W-1:0] poc_count_t;
    typedef logic [`POC_TOTAL_W-1:0] poc_total_t;

endpackage

//--- test/poc_stats_client.sv
// Client statistics logic model that sums per-frame payload counts.
// Assumes one instance per direction, on the same clock as the block.
`timescale 1ns/10ps

module poc_stats_client (
    // Clock and reset
    input wire logic                sys_clk,
    input wire logic                rst_n,
    // Per-frame report from the block
    input wire logic                strobe,
    input wire poc_pkg::poc_count_t bytes,
    // Running sum kept by the client
    output poc_pkg::poc_total_t     sum
);
    import poc_pkg::*;

    // Count is trusted only in a strobe cycle; otherwise it may be stale
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sum <= '0;
        end else if (strobe) begin
            sum <= sum + 64'(bytes);
        end
    end
endmodule

//--- test/test_payload_octet_count_reporting.sv
// Self-checking bench for the payload byte counting block.
// Assumes poc_pkg and poc_payload_count are compiled first.
`timescale 1ns/10ps

module test_payload_octet_count_reporting;
    import poc_pkg::*;

    // ---------------------------------------------------------------
    // Stimulus, observed outputs and expectations
    // ---------------------------------------------------------------
    logic       sys_clk = 1'b0;
    logic       rst_n   = 1'b0;
    logic       en      = 1'b1;
    logic [1:0] fe      = 2'b00;
    logic [1:0] stb;
    logic [1:0] bad;
    logic [3:0] er [2]  = '{4'h0, 4'h0};
    poc_count_t len [2] = '{16'h0000, 16'h0000};
    poc_count_t byt [2];
    poc_count_t exp_b [2] = '{16'h0000, 16'h0000};
    poc_total_t tot [2];
    poc_total_t sum [2];
    poc_total_t exp_t [2] = '{64'h0, 64'h0};
    poc_total_t exp_s [2] = '{64'h0, 64'h0};
    int         num_errors = 0;
    int         n_compared = 0;

    // Clock, half period 2 ns
    always #2 sys_clk = ~sys_clk;

    poc_payload_count dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .stats_module_en(en),
        .rx_frame_end(fe[0]), .rx_frame_len(len[0]), .rx_fcs_err(er[0][0]),
        .rx_oversize_err(er[0][1]), .rx_undersize_err(er[0][2]), .rx_length_err(er[0][3]),
        .tx_frame_end(fe[1]), .tx_frame_len(len[1]), .tx_fcs_err(er[1][0]),
        .tx_oversize_err(er[1][1]), .tx_undersize_err(er[1][2]), .tx_length_err(er[1][3]),
        .rx_frame_payload_bytes_strobe(stb[0]), .rx_frame_payload_bytes(byt[0]),
        .rx_bad_frame_strobe(bad[0]), .rx_good_payload_byte_total(tot[0]),
        .tx_frame_payload_bytes_strobe(stb[1]), .tx_frame_payload_bytes(byt[1]),
        .tx_bad_frame_strobe(bad[1]), .tx_good_payload_byte_total(tot[1]));
    poc_stats_client client_rx (.sys_clk(sys_clk), .rst_n(rst_n), .strobe(stb[0]),
        .bytes(byt[0]), .sum(sum[0]));
    poc_stats_client client_tx (.sys_clk(sys_clk), .rst_n(rst_n), .strobe(stb[1]),
        .bytes(byt[1]), .sum(sum[1]));

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic check(input poc_total_t seen, input poc_total_t want);
        n_compared++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    // One frame report on direction d, judged on the strobe and the next cycle
    task automatic frame(input int d, input poc_count_t l, input logic [3:0] e);
        logic good;
        good = (e === 4'h0);
        @(posedge sys_clk);
        fe[d] <= 1'b1;
        len[d] <= l;
        er[d] <= e;
        @(posedge sys_clk);
        fe[d] <= 1'b0;
        exp_b[d] = good ? l : exp_b[d];
        exp_s[d] += good ? 64'(l) : 64'h0;
        exp_t[d] += (good && en) ? 64'(l) : 64'h0;
        #1;
        check(64'(stb[d]), 64'(good));
        check(64'(bad[d]), 64'(!good));
        check(64'(byt[d]), 64'(exp_b[d]));
        @(posedge sys_clk);
        #1;
        check(64'(stb[d] | bad[d]), 64'h0);
        check(tot[d], exp_t[d]);
        check(sum[d], exp_s[d]);
    endtask

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_good();
        check(tot[0] | tot[1], 64'h0);
        frame(0, 16'h05dc, 4'h0);
        frame(1, 16'hffff, 4'h0);
        // Both directions at once must not disturb each other
        fork
            frame(0, 16'h0040, 4'h0);
            frame(1, 16'h002e, 4'h0);
        join
        $display("good frames done");
    endtask

    // Every error kind alone and all together, both directions
    task automatic t_errors();
        for (int d = 0; d < 2; d++) begin
            for (int b = 0; b < 5; b++) begin
                frame(d, 16'h0123, (b == 4) ? 4'hf : 4'h1 << b);
            end
        end
        $display("errored frames done");
    endtask

    // Per-frame outputs keep working with the statistics module absent
    task automatic t_no_stats();
        @(posedge sys_clk);
        en <= 1'b0;
        frame(0, 16'h0200, 4'h0);
        frame(1, 16'h0033, 4'h0);
        @(posedge sys_clk);
        en <= 1'b1;
        $display("no statistics module done");
    endtask

    // Back-to-back reports, one per cycle
    task automatic t_burst();
        for (int i = 1; i <= 3; i++) begin
            @(posedge sys_clk);
            fe[0] <= 1'b1;
            len[0] <= 16'(i);
            er[0] <= 4'h0;
            exp_t[0] += 64'(i);
            exp_s[0] += 64'(i);
        end
        @(posedge sys_clk);
        fe[0] <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check(tot[0], exp_t[0]);
        check(sum[0], exp_s[0]);
        check(64'(byt[0]), 64'h3);
        exp_b[0] = 16'h0003;
        $display("burst done");
    endtask

    // Main sequence: reset for 3 cycles, then the scenarios
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_good();
        t_errors();
        t_no_stats();
        t_burst();
        test_done();
    end

    // Watchdog, about seventeen times the expected run
    initial begin
        #4000;
        num_errors++;
        test_done();
    end
endmodule
